// file: osor_regs.sv
// Output status and override holding register bank
//
// Functional notes
// - Analog output local-override word, bits 0-3 are outputs 1-4, set means active.
// - Digital output local-override word at the next register, set means active.
// - Digital bit maps: bit0 solenoid 1, bit1 solenoid 2, bit2 relay 1, bit3 relay 2.
// - Analog output alarm word, bit set while that output's alarm is active.
// - Digital output alarm word, bit set while that output's alarm is active.
// - Analog output recopy word, bit set while recopy is active.
// - Digital output recopy word, bit set while recopy is active.
// - Writable analog override command; set bit overrides output, clear releases.
// - Writable digital override command; set bit puts that output under override.
// - Bits 4 to 15 of every status and command word read as zero.
// - Read-write 16-bit override value word for digital input 1.
// - Override value write ignored while its channel is in pulse-width mode.
`default_nettype none
module osor_regs
   import osor_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire osor_pkg::osor_req_t req_i,
   input wire osor_pkg::osor_chan_status_t ao_status_i,
   input wire osor_pkg::osor_chan_status_t do_status_i,
   input wire logic di1_pwm_mode_i,
   output logic [osor_pkg::WORD_W-1:0] rdata_o,
   output logic rvalid_o,
   output logic rerr_o,
   output logic [osor_pkg::CHAN_N-1:0] ao_remote_override_o,
   output logic [osor_pkg::CHAN_N-1:0] do_remote_override_o,
   output logic [osor_pkg::WORD_W-1:0] input1_discrete_override_value_o,
   output logic di1_override_active_o
);
   import osor_pkg::*;

   logic [CHAN_N-1:0] ao_cmd;
   logic [CHAN_N-1:0] do_cmd;
   logic [WORD_W-1:0] di1_val;
   logic [WORD_W-1:0] next_rdata;
   logic hit;

   localparam logic [WORD_W-CHAN_N-1:0] PAD = '0;

   wire sel_ao_lo = req_i.addr == ADDR_AO_LOCAL_OVR;
   wire sel_do_lo = req_i.addr == ADDR_DO_LOCAL_OVR;
   wire sel_ao_al = req_i.addr == ADDR_AO_ALARM;
   wire sel_do_al = req_i.addr == ADDR_DO_ALARM;
   wire sel_ao_rc = req_i.addr == ADDR_AO_RECOPY;
   wire sel_do_rc = req_i.addr == ADDR_DO_RECOPY;
   wire sel_ao_cmd = req_i.addr == ADDR_AO_OVR_CMD;
   wire sel_do_cmd = req_i.addr == ADDR_DO_OVR_CMD;
   wire sel_di1 = req_i.addr == ADDR_DI1_OVR_VAL;

   // Write enables; read-only words have none
   wire wr_ao_cmd = req_i.wr && sel_ao_cmd;
   wire wr_do_cmd = req_i.wr && sel_do_cmd;
   wire wr_di1 = req_i.wr && sel_di1 && !di1_pwm_mode_i;

   // Read mux, upper bits padded with zero
   always_comb begin
      hit = 1'b1;
      case (1'b1)
         sel_ao_lo: next_rdata = {PAD, ao_status_i.local_override};
         sel_do_lo: next_rdata = {PAD, do_status_i.local_override};
         sel_ao_al: next_rdata = {PAD, ao_status_i.alarm};
         sel_do_al: next_rdata = {PAD, do_status_i.alarm};
         sel_ao_rc: next_rdata = {PAD, ao_status_i.recopy};
         sel_do_rc: next_rdata = {PAD, do_status_i.recopy};
         sel_ao_cmd: next_rdata = {PAD, ao_cmd};
         sel_do_cmd: next_rdata = {PAD, do_cmd};
         sel_di1: next_rdata = di1_val;
         default: begin
            next_rdata = '0;
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ao_cmd <= RST_OVR_CMD;
         do_cmd <= RST_OVR_CMD;
         di1_val <= RST_OVR_VAL;
      end else begin
         if (wr_ao_cmd) ao_cmd <= req_i.wdata[CHAN_N-1:0];
         if (wr_do_cmd) do_cmd <= req_i.wdata[CHAN_N-1:0];
         if (wr_di1) di1_val <= req_i.wdata;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
         rvalid_o <= 1'b0;
         rerr_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
         rerr_o <= req_i.rd && !hit;
         if (req_i.rd) rdata_o <= next_rdata;
      end
   end

   assign ao_remote_override_o = ao_cmd;
   assign do_remote_override_o = do_cmd;
   assign input1_discrete_override_value_o = di1_val;
   assign di1_override_active_o = !di1_pwm_mode_i;

   // Write path checks
   a_ao_cmd_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_ao_cmd |=> ao_cmd == $past(req_i.wdata[CHAN_N-1:0]))
      else $error("analog override command not stored");
   a_do_cmd_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_do_cmd |=> do_cmd == $past(req_i.wdata[CHAN_N-1:0]))
      else $error("digital override command not stored");
   a_ao_ovr_output: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_ao_cmd |=> ao_remote_override_o == $past(req_i.wdata[CHAN_N-1:0]))
      else $error("analog override output not updated");
   a_do_ovr_output: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_do_cmd |=> do_remote_override_o == $past(req_i.wdata[CHAN_N-1:0]))
      else $error("digital override output not updated");
   a_ao_cmd_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !wr_ao_cmd |=> $stable(ao_cmd))
      else $error("analog override command changed without write");
   a_do_cmd_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !wr_do_cmd |=> $stable(do_cmd))
      else $error("digital override command changed without write");
   a_di1_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_di1 |=> di1_val == $past(req_i.wdata))
      else $error("override value not stored");
   a_di1_out: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_di1 |=> input1_discrete_override_value_o == $past(req_i.wdata))
      else $error("override value output not updated");
   a_pwm_write_ignored: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.wr && sel_di1 && di1_pwm_mode_i |=> $stable(di1_val))
      else $error("override value changed in pulse mode");
   a_di1_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !wr_di1 |=> $stable(di1_val))
      else $error("override value changed without write");

   // Status words ignore writes
   a_ro_write_safe: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.wr && sel_ao_al |=> $stable(ao_cmd) && $stable(do_cmd) && $stable(di1_val))
      else $error("write to status word changed state");
   a_ro_write_other: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.wr && !sel_ao_cmd && !sel_do_cmd && !sel_di1
         |=> $stable(ao_cmd) && $stable(do_cmd) && $stable(di1_val))
      else $error("write outside writable words changed state");

   // Read path checks
   a_upper_zero: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rvalid_o && $past(!sel_di1) |-> rdata_o[WORD_W-1:CHAN_N] == '0)
      else $error("unused bits read nonzero");
   a_ao_lo_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_ao_lo |=> rdata_o[CHAN_N-1:0] == $past(ao_status_i.local_override))
      else $error("analog local override misread");
   a_do_lo_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_do_lo |=> rdata_o[CHAN_N-1:0] == $past(do_status_i.local_override))
      else $error("digital local override misread");
   a_alarm_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_ao_al |=> rdata_o[CHAN_N-1:0] == $past(ao_status_i.alarm))
      else $error("analog alarm misread");
   a_do_alarm_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_do_al |=> rdata_o[CHAN_N-1:0] == $past(do_status_i.alarm))
      else $error("digital alarm misread");
   a_ao_rc_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_ao_rc |=> rdata_o[CHAN_N-1:0] == $past(ao_status_i.recopy))
      else $error("analog recopy misread");
   a_recopy_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_do_rc |=> rdata_o[CHAN_N-1:0] == $past(do_status_i.recopy))
      else $error("digital recopy misread");
   a_ao_cmd_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_ao_cmd |=> rdata_o == {PAD, $past(ao_cmd)})
      else $error("analog override command misread");
   a_do_cmd_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_do_cmd |=> rdata_o == {PAD, $past(do_cmd)})
      else $error("digital override command misread");
   a_di1_read: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && sel_di1 |=> rdata_o == $past(di1_val))
      else $error("override value misread");

   // Read answer and error flag
   a_read_answer: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd |=> rvalid_o)
      else $error("read not answered");
   a_no_stray_answer: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !req_i.rd |=> !rvalid_o && !rerr_o)
      else $error("answer without read");
   a_unmapped_flag: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && !hit |=> rerr_o && rdata_o == '0)
      else $error("unmapped read not flagged");
   a_mapped_no_err: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && hit |=> !rerr_o)
      else $error("mapped read flagged as error");
   a_rdata_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !req_i.rd |=> $stable(rdata_o))
      else $error("read data changed without read");
endmodule
`default_nettype wire

// file: osor_pkg.sv
// Package for the output status and override register bank
`default_nettype none
package osor_pkg;
   localparam int WORD_W = 16;
   localparam int CHAN_N = 4;
   localparam int ADDR_W = 16;
   // Register addresses (holding register numbers as offsets)
   localparam logic [ADDR_W-1:0] ADDR_AO_LOCAL_OVR = 16'h9c4b;
   localparam logic [ADDR_W-1:0] ADDR_DO_LOCAL_OVR = 16'h9c4c;
   localparam logic [ADDR_W-1:0] ADDR_AO_ALARM = 16'h9c4d;
   localparam logic [ADDR_W-1:0] ADDR_DO_ALARM = 16'h9c4e;
   localparam logic [ADDR_W-1:0] ADDR_AO_RECOPY = 16'h9c4f;
   localparam logic [ADDR_W-1:0] ADDR_DO_RECOPY = 16'h9c50;
   localparam logic [ADDR_W-1:0] ADDR_AO_OVR_CMD = 16'h9c51;
   localparam logic [ADDR_W-1:0] ADDR_DO_OVR_CMD = 16'h9c52;
   localparam logic [ADDR_W-1:0] ADDR_DI1_OVR_VAL = 16'ha028;
   // Reset values
   localparam logic [CHAN_N-1:0] RST_OVR_CMD = 4'h0;
   localparam logic [WORD_W-1:0] RST_OVR_VAL = 16'h0000;
   // Digital output bit positions
   localparam int BIT_SOLENOID_OUT_1 = 0;
   localparam int BIT_SOLENOID_OUT_2 = 1;
   localparam int BIT_RELAY_OUT_1 = 2;
   localparam int BIT_RELAY_OUT_2 = 3;

   typedef struct packed {
      logic [CHAN_N-1:0] local_override;
      logic [CHAN_N-1:0] alarm;
      logic [CHAN_N-1:0] recopy;
   } osor_chan_status_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } osor_req_t;
endpackage
`default_nettype wire

// file: osor_master.sv
// Register bus master model
`default_nettype none
module osor_master
   import osor_pkg::*;
(
   input wire logic mclk_i,
   output var osor_pkg::osor_req_t req_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import osor_pkg::*;
   initial req_o = '0;
   // Request raised on one rising edge, taken and dropped on the next
   task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge mclk_i);
      req_o <= '0;
   endtask
endmodule
`default_nettype wire

// file: osor_regs_tb.sv
// Self-checking bench for the register bank
`default_nettype none
module osor_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import osor_pkg::*;
   logic mclk_i = 0;
   logic rst_i = 1;
   logic pwm = 0;
   osor_req_t req;
   osor_chan_status_t ao_st = '0, do_st = '0;
   logic [15:0] rdata, val;
   logic rvalid, rerr, act;
   logic [3:0] ao_ovr, do_ovr;
   int bad_count = 0;
   int checks_done = 0;
   logic [15:0] exp [6] = '{16'h1, 16'he, 16'h3, 16'hc, 16'h7, 16'h8};
   always #12.5 mclk_i = ~mclk_i;
   osor_master m (.mclk_i(mclk_i), .req_o(req));
   osor_regs dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .ao_status_i(ao_st),
      .do_status_i(do_st), .di1_pwm_mode_i(pwm), .rdata_o(rdata), .rvalid_o(rvalid),
      .rerr_o(rerr), .ao_remote_override_o(ao_ovr), .do_remote_override_o(do_ovr),
      .input1_discrete_override_value_o(val), .di1_override_active_o(act));
   task automatic check(input logic [15:0] s, input logic [15:0] e, input string w);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic er);
      m.access(1'b0, a, 16'h0);
      @(negedge mclk_i);
      check(rvalid, 1'b1, "rvalid");
      check(rerr, er, "rerr");
      check(rdata, e, "rdata");
      @(negedge mclk_i);
      check(rvalid, 1'b0, "rvalid end");
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      m.access(1'b1, a, d);
      @(negedge mclk_i);
      check(rvalid, 1'b0, "write rvalid");
   endtask
   // Status words, then writes to them change nothing
   task automatic t_status();
      for (int i = 0; i < 6; i++) begin
         rd(ADDR_AO_LOCAL_OVR + 16'(i), exp[i], 1'b0);
         wr(ADDR_AO_LOCAL_OVR + 16'(i), 16'hffff);
         rd(ADDR_AO_LOCAL_OVR + 16'(i), exp[i], 1'b0);
      end
   endtask
   // Override commands set, analog one then released
   task automatic t_cmd();
      wr(ADDR_AO_OVR_CMD, 16'hfffa);
      check(ao_ovr, 16'ha, "ao_ovr");
      rd(ADDR_AO_OVR_CMD, 16'h000a, 1'b0);
      wr(ADDR_AO_OVR_CMD, 16'h0000);
      check(ao_ovr, 16'h0, "ao_ovr");
      wr(ADDR_DO_OVR_CMD, 16'h0005);
      check(do_ovr, 16'h5, "do_ovr");
      rd(ADDR_DO_OVR_CMD, 16'h0005, 1'b0);
      rd(16'h9c53, 16'h0, 1'b1);
   endtask
   // Value word, ignored in pulse-width mode
   task automatic t_value();
      wr(ADDR_DI1_OVR_VAL, 16'h1234);
      check(val, 16'h1234, "val");
      rd(ADDR_DI1_OVR_VAL, 16'h1234, 1'b0);
      @(posedge mclk_i);
      pwm <= 1'b1;
      wr(ADDR_DI1_OVR_VAL, 16'hbeef);
      check(val, 16'h1234, "val");
      check(act, 1'b0, "active");
      rd(ADDR_DI1_OVR_VAL, 16'h1234, 1'b0);
      @(posedge mclk_i);
      pwm <= 1'b0;
      @(negedge mclk_i);
      check(act, 1'b1, "active");
   endtask
   // Mid-run reset clears commands and value
   task automatic t_reset();
      wr(ADDR_AO_OVR_CMD, 16'h0005);
      wr(ADDR_DO_OVR_CMD, 16'h000a);
      check(do_ovr, 16'ha, "do_ovr");
      wr(ADDR_DI1_OVR_VAL, 16'h55aa);
      check(val, 16'h55aa, "val");
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(negedge mclk_i);
      check({ao_ovr, do_ovr}, 16'h0, "reset cmds");
      check(val, 16'h0, "reset value");
      rd(ADDR_DI1_OVR_VAL, 16'h0, 1'b0);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge mclk_i);
      bad_count++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      ao_st <= '{local_override: 4'h1, alarm: 4'h3, recopy: 4'h7};
      do_st <= '{local_override: 4'he, alarm: 4'hc, recopy: 4'h8};
      rst_i <= 1'b0;
      @(negedge mclk_i);
      check({ao_ovr, do_ovr, rvalid, rerr}, 16'h0, "reset outputs");
      check(rdata, 16'h0, "reset rdata");
      check(val, 16'h0, "reset value");
      check(act, 1'b1, "active");
      t_status();
      t_cmd();
      t_value();
      t_reset();
      conclude();
   end
endmodule
`default_nettype wire
